// ### include/ddil_pkg.sv
// constants and carrier types for the depressurization initiation logic
package ddil_pkg;
  // clock and timer base
  localparam int unsigned CLK_HZ        = 200_000_000;
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYC_I    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int unsigned ACT_DELAY_S   = 29;
  localparam int unsigned BYP_DELAY_MIN = 8;
  localparam int unsigned ACT_TICKS_I   = ACT_DELAY_S * 1_000_000 / TICK_US;
  localparam int unsigned BYP_TICKS_I   =
    BYP_DELAY_MIN * 60 * 1_000_000 / TICK_US;
  localparam int unsigned CNT_W         = 20;
  localparam logic [19:0] TICK_CYCLES   = 20'(TICK_CYC_I);
  localparam logic [19:0] ACT_TICKS     = 20'(ACT_TICKS_I);
  localparam logic [19:0] BYP_TICKS     = 20'(BYP_TICKS_I);
  // plant sizes
  localparam int unsigned NUM_VLV   = 18;
  localparam int unsigned NUM_PILOT = 8;
  localparam int unsigned NUM_GRP   = 3;
  localparam int unsigned GRP_SIZE  = 6;
  localparam int unsigned NUM_CIRC  = 2;
  localparam int unsigned VOTE_MIN  = 2;
  // register map, byte addresses
  localparam logic [7:0] REG_STATUS  = 8'h00;
  localparam logic [7:0] REG_CTRL    = 8'h04;
  localparam logic [7:0] REG_POS     = 8'h08;
  localparam logic [7:0] REG_BYP_TMR = 8'h0C;
  localparam logic [7:0] REG_RELIEF  = 8'h10;
  localparam logic [7:0] REG_ACT_TMR = 8'h14;
  localparam logic [7:0] ADDR_MASK   = 8'hFC;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // status bit positions
  localparam int ST_DW_SEAL  = 0;
  localparam int ST_LVL_SEAL = 1;
  localparam int ST_INIT     = 2;
  localparam int ST_TIMING   = 3;
  localparam int ST_INHIBIT  = 4;
  localparam int ST_ARMED    = 5;
  localparam int ST_PERMIT   = 6;
  localparam int ST_LEAK     = 7;
  localparam int ST_MAN_INIT = 8;
  localparam int ST_TEST_VOTE = 9;
  localparam int ST_TWS_OK   = 10;
  // control fields
  localparam int         CTRL_TEST_EN  = 0;
  localparam int         CTRL_INJ_LSB  = 4;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [7:0] CTRL_WMASK    = 8'hF1;

  typedef struct packed {
    logic [3:0]  dw_trip;
    logic [3:0]  lvl_trip;
    logic [3:0]  press_trip;
    logic [2:0]  lpf_run;
    logic [1:0]  hpf_run;
    logic        lvl15_low;
    logic        prm_low;
    logic        tws_inhibit;
    logic        div_inhibit;
    logic [1:0]  arm_collar;
    logic [1:0]  pushbutton;
    logic        reset_req;
    logic [17:0] sel_open;
    logic [17:0] sel_auto;
    logic [17:0] limit_sw;
    logic [17:0] temp_hi;
  } ddil_in_s;

  typedef struct packed {
    ddil_in_s          s1;
    ddil_in_s          s2;
    logic [19:0]       tick_cnt;
    logic              tick;
    logic [1:0][19:0]  byp;
    logic [1:0][19:0]  act;
    logic              dw_seal;
    logic              lvl_seal;
    logic              init;
    logic              man_init;
    logic              ann_timing;
    logic              ann_inhibit;
    logic              ann_armed;
    logic              ann_leak;
    logic [7:0]        pilot;
    logic [17:0]       relief;
    logic [2:0]        grp;
    logic [17:0]       pos;
    logic [7:0]        ctrl;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        awaddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
  } ddil_st_s;
endpackage

// ### rtl/ddil_top.sv
// one division of depressurization initiation, interlock and actuation
//
// Notes on behaviour
// - initiate on drywell seal plus lowest level, or lowest level alone after bypass
// - both parameters voted two of four; level must hold through timing
// - each voted parameter latches and annunciates until manual reset
// - automatic action needs any flooder pump discharge pressure permissive
// - 29 s after drywell plus level, or 8 min then 29 s on level
// - after initiation and delay, pilot solenoid outputs energize and hold
// - this division drives its own pilot on every depressurization valve
// - manual reset of initiation ignored while drywell and level are both still voted two of four
// - division inhibit blocks only before initiation, never closes valves
// - inhibit annunciation stays on while division inhibit is active
// - both arming collars raise armed annunciation before pushbuttons act
// - both armed pushbuttons open valves at once if pumps running
// - per valve selector: off, automatic, or manual open
// - eighteen relief valves in three groups of six by power division
// - auto initiation only with power and level below setpoints, no inhibit
// - two circuits with own timers must both assert to initiate
// - test injection never blocks or delays genuine automatic operation
// - limit switches forwarded as position status
// - relief valves open on reactor pressure vote, apart from timers
// - any discharge line over temperature raises leakage alarm
// - level recovery before timeout clears timers; each dip restarts
// - timing annunciation while either delay timer counts
`timescale 1ns/1ps
`default_nettype none

module ddil_top #(
  parameter logic [19:0] P_TICK_CYCLES = ddil_pkg::TICK_CYCLES,
  parameter logic [19:0] P_ACT_TICKS   = ddil_pkg::ACT_TICKS,
  parameter logic [19:0] P_BYP_TICKS   = ddil_pkg::BYP_TICKS
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire ddil_pkg::ddil_in_s i_plant,
  input  wire logic [7:0]        i_s_awaddr,
  input  wire logic              i_s_awvalid,
  output logic                   o_s_awready,
  input  wire logic [31:0]       i_s_wdata,
  input  wire logic [3:0]        i_s_wstrb,
  input  wire logic              i_s_wvalid,
  output logic                   o_s_wready,
  output logic [1:0]             o_s_bresp,
  output logic                   o_s_bvalid,
  input  wire logic              i_s_bready,
  input  wire logic [7:0]        i_s_araddr,
  input  wire logic              i_s_arvalid,
  output logic                   o_s_arready,
  output logic [31:0]            o_s_rdata,
  output logic [1:0]             o_s_rresp,
  output logic                   o_s_rvalid,
  input  wire logic              i_s_rready,
  output logic [7:0]             o_pilot_sol,
  output logic [17:0]            o_relief_sol,
  output logic [2:0]             o_group_relief,
  output logic [17:0]            o_pos_status,
  output logic                   o_ann_dw_seal,
  output logic                   o_ann_lvl_seal,
  output logic                   o_ann_init,
  output logic                   o_ann_timing,
  output logic                   o_ann_inhibit,
  output logic                   o_ann_armed,
  output logic                   o_ann_leak
);

  ddil_pkg::ddil_st_s q;
  ddil_pkg::ddil_st_s d;

  logic        dw_v;
  logic        lvl_v;
  logic        prs_v;
  logic        perm;
  logic        tws_ok;
  logic        hold;
  logic        armed;
  logic        man_fire;
  logic        auto_fire;
  logic        counting;
  logic        test_vote;
  logic        aw_rdy;
  logic        w_rdy;
  logic        ar_rdy;
  logic [1:0]  byp_done;
  logic [1:0]  act_done;
  logic [31:0] status;
  logic [7:0]  waddr;
  logic [7:0]  raddr;

  function automatic logic vote2(input logic [3:0] c);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 4; i++) begin
      n = n + {2'b00, c[i]};
    end
    return n >= 3'(ddil_pkg::VOTE_MIN);
  endfunction

  always_comb begin
    // votes look only at the second synchroniser stage
    dw_v      = vote2(q.s2.dw_trip);
    lvl_v     = vote2(q.s2.lvl_trip);
    prs_v     = vote2(q.s2.press_trip);
    perm      = (|q.s2.lpf_run) | (|q.s2.hpf_run);
    tws_ok    = q.s2.prm_low & q.s2.lvl15_low
                & ~q.s2.tws_inhibit;
    // once initiated the inhibits lose their grip
    hold      = (q.s2.div_inhibit | ~tws_ok) & ~q.init;
    armed     = &q.s2.arm_collar;
    man_fire  = armed & (&q.s2.pushbutton) & perm;
    // test injection is a shadow vote that feeds status only
    test_vote = q.ctrl[ddil_pkg::CTRL_TEST_EN]
                & vote2(q.ctrl[ddil_pkg::CTRL_INJ_LSB +: 4]);
    counting  = 1'b0;
    for (int c = 0; c < ddil_pkg::NUM_CIRC; c++) begin
      byp_done[c] = (q.byp[c] == P_BYP_TICKS);
      act_done[c] = (q.act[c] == P_ACT_TICKS);
      if (lvl_v && !hold) begin
        if ((!q.dw_seal && !byp_done[c])
            || ((q.dw_seal || byp_done[c]) && !act_done[c])) begin
          counting = 1'b1;
        end
      end
    end
    auto_fire = (&act_done) & perm & tws_ok & lvl_v;
    aw_rdy    = ~q.aw_got & ~q.bvalid;
    w_rdy     = ~q.w_got & ~q.bvalid;
    ar_rdy    = ~q.rvalid;
    waddr     = q.awaddr & ddil_pkg::ADDR_MASK;
    raddr     = i_s_araddr & ddil_pkg::ADDR_MASK;
    status    = 32'h0000_0000;
    status[ddil_pkg::ST_DW_SEAL]   = q.dw_seal;
    status[ddil_pkg::ST_LVL_SEAL]  = q.lvl_seal;
    status[ddil_pkg::ST_INIT]      = q.init;
    status[ddil_pkg::ST_TIMING]    = q.ann_timing;
    status[ddil_pkg::ST_INHIBIT]   = q.ann_inhibit;
    status[ddil_pkg::ST_ARMED]     = q.ann_armed;
    status[ddil_pkg::ST_PERMIT]    = perm;
    status[ddil_pkg::ST_LEAK]      = q.ann_leak;
    status[ddil_pkg::ST_MAN_INIT]  = q.man_init;
    status[ddil_pkg::ST_TEST_VOTE] = test_vote;
    status[ddil_pkg::ST_TWS_OK]    = tws_ok;

    d = q;
    // two stages; stage one feeds stage two and nothing else
    d.s1 = i_plant;
    d.s2 = q.s1;

    // timer tick divider
    d.tick = 1'b0;
    if (q.tick_cnt >= P_TICK_CYCLES - 20'h1) begin
      d.tick_cnt = 20'h0;
      d.tick     = 1'b1;
    end else begin
      d.tick_cnt = q.tick_cnt + 20'h1;
    end

    // parameter seal-ins; set wins over a reset in the same cycle
    if (dw_v) begin
      d.dw_seal = 1'b1;
    end else if (q.s2.reset_req) begin
      d.dw_seal = 1'b0;
    end
    if (lvl_v) begin
      d.lvl_seal = 1'b1;
    end else if (q.s2.reset_req) begin
      d.lvl_seal = 1'b0;
    end

    // per circuit delay chain: bypass timer then actuation timer
    for (int c = 0; c < ddil_pkg::NUM_CIRC; c++) begin
      if (!lvl_v || hold) begin
        d.byp[c] = 20'h0;
        d.act[c] = 20'h0;
      end else if (q.tick) begin
        if (!q.dw_seal && !byp_done[c]) begin
          d.byp[c] = q.byp[c] + 20'h1;
        end
        if ((q.dw_seal || byp_done[c]) && !act_done[c]) begin
          d.act[c] = q.act[c] + 20'h1;
        end
      end
    end

    // initiation latch; reset clears it unless both trips are still voted
    if (auto_fire || man_fire) begin
      d.init     = 1'b1;
      d.man_init = q.man_init | man_fire;
    end else if (q.s2.reset_req && !(dw_v && lvl_v)) begin
      d.init     = 1'b0;
      d.man_init = 1'b0;
    end
    d.pilot = {ddil_pkg::NUM_PILOT{d.init}};

    // relief valves: manual open, or auto on pressure vote
    for (int i = 0; i < ddil_pkg::NUM_VLV; i++) begin
      d.relief[i] = q.s2.sel_open[i]
                    | (q.s2.sel_auto[i] & prs_v);
    end
    for (int g = 0; g < ddil_pkg::NUM_GRP; g++) begin
      d.grp[g] = |d.relief[g * ddil_pkg::GRP_SIZE +: 6];
    end

    d.ann_timing  = counting;
    d.ann_inhibit = q.s2.div_inhibit;
    d.ann_armed   = armed;
    d.ann_leak    = |q.s2.temp_hi;
    d.pos         = q.s2.limit_sw;

    // register bus: write address and data taken in either order
    if (i_s_awvalid && aw_rdy) begin
      d.aw_got = 1'b1;
      d.awaddr = i_s_awaddr;
    end
    if (i_s_wvalid && w_rdy) begin
      d.w_got = 1'b1;
      d.wdata = i_s_wdata;
      d.wstrb = i_s_wstrb;
    end
    if (q.aw_got && q.w_got) begin
      d.aw_got = 1'b0;
      d.w_got  = 1'b0;
      d.bvalid = 1'b1;
      d.bresp  = ddil_pkg::RESP_OKAY;
      unique case (waddr)
        ddil_pkg::REG_CTRL: begin
          if (q.wstrb[0]) begin
            d.ctrl = q.wdata[7:0] & ddil_pkg::CTRL_WMASK;
          end
        end
        ddil_pkg::REG_STATUS, ddil_pkg::REG_POS, ddil_pkg::REG_BYP_TMR,
        ddil_pkg::REG_RELIEF, ddil_pkg::REG_ACT_TMR: begin
          d.bresp = ddil_pkg::RESP_OKAY;
        end
        default: begin
          d.bresp = ddil_pkg::RESP_SLVERR;
        end
      endcase
    end else if (q.bvalid && i_s_bready) begin
      d.bvalid = 1'b0;
    end

    if (i_s_arvalid && ar_rdy) begin
      d.rvalid = 1'b1;
      d.rresp  = ddil_pkg::RESP_OKAY;
      unique case (raddr)
        ddil_pkg::REG_STATUS:  d.rdata = status;
        ddil_pkg::REG_CTRL:    d.rdata = {24'h000000, q.ctrl};
        ddil_pkg::REG_POS:     d.rdata = {14'h0000, q.pos};
        ddil_pkg::REG_BYP_TMR: d.rdata = {12'h000, q.byp[0]};
        ddil_pkg::REG_RELIEF:  d.rdata = {14'h0000, q.relief};
        ddil_pkg::REG_ACT_TMR: d.rdata = {12'h000, q.act[0]};
        default: begin
          d.rdata = 32'h0000_0000;
          d.rresp = ddil_pkg::RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid && i_s_rready) begin
      d.rvalid = 1'b0;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign o_s_awready    = aw_rdy;
  assign o_s_wready     = w_rdy;
  assign o_s_arready    = ar_rdy;
  assign o_s_bvalid     = q.bvalid;
  assign o_s_bresp      = q.bresp;
  assign o_s_rvalid     = q.rvalid;
  assign o_s_rresp      = q.rresp;
  assign o_s_rdata      = q.rdata;
  assign o_pilot_sol    = q.pilot;
  assign o_relief_sol   = q.relief;
  assign o_group_relief = q.grp;
  assign o_pos_status   = q.pos;
  assign o_ann_dw_seal  = q.dw_seal;
  assign o_ann_lvl_seal = q.lvl_seal;
  assign o_ann_init     = q.init;
  assign o_ann_timing   = q.ann_timing;
  assign o_ann_inhibit  = q.ann_inhibit;
  assign o_ann_armed    = q.ann_armed;
  assign o_ann_leak     = q.ann_leak;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  property p_seal_set;
    dw_v |=> o_ann_dw_seal;
  endproperty
  a_seal_set: assert property (p_seal_set) else $error("seal missed");

  property p_reset_blocked;
    q.lvl_seal && lvl_v && q.s2.reset_req |=> q.lvl_seal;
  endproperty
  a_reset_blocked: assert property (p_reset_blocked)
    else $error("seal cleared with trip present");

  property p_inhibit_ann;
    q.s2.div_inhibit |=> o_ann_inhibit;
  endproperty
  a_inhibit_ann: assert property (p_inhibit_ann)
    else $error("inhibit not annunciated");

  property p_no_abort;
    q.init && dw_v && lvl_v |=> q.init && o_pilot_sol == 8'hFF;
  endproperty
  a_no_abort: assert property (p_no_abort)
    else $error("valves closed while trips present");

  property p_manual;
    man_fire |=> o_ann_init ##1 o_pilot_sol == 8'hFF;
  endproperty
  a_manual: assert property (p_manual)
    else $error("manual fire did not open");

  property p_permit;
    $rose(q.init) |-> $past(perm);
  endproperty
  a_permit: assert property (p_permit)
    else $error("initiation without pump permissive");

  property p_level_reset;
    !lvl_v |=> q.byp[0] == 20'h0 && q.act[1] == 20'h0;
  endproperty
  a_level_reset: assert property (p_level_reset)
    else $error("timer kept after level recovery");

  property p_pilot;
    $rose(q.init) |-> o_pilot_sol == 8'hFF;
  endproperty
  a_pilot: assert property (p_pilot)
    else $error("pilot not energized with initiation");

  property p_relief;
    prs_v && q.s2.sel_auto[0] |=> o_relief_sol[0] && o_group_relief[0];
  endproperty
  a_relief: assert property (p_relief)
    else $error("relief not commanded on pressure");

  property p_leak;
    q.s2.temp_hi[17] |=> o_ann_leak;
  endproperty
  a_leak: assert property (p_leak)
    else $error("leak alarm missed");

  property p_tws_hold;
    !tws_ok && !q.init |=> q.act[0] == 20'h0;
  endproperty
  a_tws_hold: assert property (p_tws_hold)
    else $error("timer ran under transient inhibit");

  c_auto_init: cover property ($rose(q.init) && !man_fire);
  c_manual: cover property (man_fire ##1 q.init);
  c_relief: cover property ($rose(o_relief_sol[5]));
  c_inhibit: cover property (q.s2.div_inhibit && lvl_v && dw_v);

endmodule

`default_nettype wire

// ### testbench/ddil_valve_model.sv
// relief valve and limit switch model behind the solenoid outputs
`timescale 1ns/1ps
`default_nettype none

module ddil_valve_model (
  input  wire logic        i_mclk,
  input  wire logic [7:0]  i_pilot,
  input  wire logic [17:0] i_relief,
  output logic      [17:0] o_limit
);
  logic [17:0] open_q = 18'h00000;

  // either solenoid opens a valve; the stroke takes two cycles,
  // so the switches never track the command in the same cycle
  always @(posedge i_mclk) begin
    open_q  <= i_relief | {10'h000, i_pilot};
    o_limit <= open_q;
  end
  initial o_limit = 18'h00000;
endmodule

`default_nettype wire

// ### testbench/ddil_top_bench.sv
// self-checking bench for the depressurization initiation logic
`timescale 1ns/1ps
`default_nettype none

module ddil_top_bench;
  // shortened counts: tick of 4 cycles, 5 and 10 ticks
  localparam int ADC = 20;
  localparam int BYC = 40;
  logic               i_mclk = 1'b0;
  logic               i_rstn = 1'b0;
  ddil_pkg::ddil_in_s cmd    = '0;
  ddil_pkg::ddil_in_s plant;
  logic [17:0]        limit;
  logic [7:0]         awaddr = 8'h00;
  logic [7:0]         araddr = 8'h00;
  logic [31:0]        wdata  = 32'h0;
  logic [3:0]         wstrb  = 4'h0;
  logic               awvalid = 1'b0;
  logic               wvalid = 1'b0;
  logic               bready = 1'b0;
  logic               arvalid = 1'b0;
  logic               rready = 1'b0;
  logic               awready, wready, bvalid, arready, rvalid;
  logic [1:0]         bresp, rresp;
  logic [31:0]        rdata;
  logic [7:0]         pilot;
  logic [17:0]        relief, pos;
  logic [2:0]         grp;
  logic               a_dw, a_lv, a_in, a_tm, a_ih, a_ar, a_lk;
  int                 mismatches = 0;
  int                 checked = 0;

  always #2.5 i_mclk = ~i_mclk;
  always_comb begin
    plant = cmd;
    plant.limit_sw = limit;
  end

  ddil_top #(.P_TICK_CYCLES(20'h00004), .P_ACT_TICKS(20'h00005),
    .P_BYP_TICKS(20'h0000A)) ddil_top_i (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_plant(plant),
    .i_s_awaddr(awaddr), .i_s_awvalid(awvalid), .o_s_awready(awready),
    .i_s_wdata(wdata), .i_s_wstrb(wstrb), .i_s_wvalid(wvalid),
    .o_s_wready(wready), .o_s_bresp(bresp), .o_s_bvalid(bvalid),
    .i_s_bready(bready), .i_s_araddr(araddr), .i_s_arvalid(arvalid),
    .o_s_arready(arready), .o_s_rdata(rdata), .o_s_rresp(rresp),
    .o_s_rvalid(rvalid), .i_s_rready(rready), .o_pilot_sol(pilot),
    .o_relief_sol(relief), .o_group_relief(grp), .o_pos_status(pos),
    .o_ann_dw_seal(a_dw), .o_ann_lvl_seal(a_lv), .o_ann_init(a_in),
    .o_ann_timing(a_tm), .o_ann_inhibit(a_ih), .o_ann_armed(a_ar),
    .o_ann_leak(a_lk));

  ddil_valve_model ddil_valve_model_i (
    .i_mclk(i_mclk), .i_pilot(pilot), .i_relief(relief), .o_limit(limit));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge i_mclk);
  endtask

  // write: address and data offered together, each released when taken
  task automatic wchk(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, input logic [1:0] er);
    logic bd;
    bd = 1'b0;
    @(posedge i_mclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bd) begin
      @(posedge i_mclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        bd = 1'b1;
        bready <= 1'b0;
        check(32'(bresp), 32'(er));
      end
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed,
                      input logic [1:0] er);
    logic rdn;
    rdn = 1'b0;
    @(posedge i_mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rdn) begin
      @(posedge i_mclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rdn = 1'b1;
        rready <= 1'b0;
        check(rdata, ed);
        check(32'(rresp), 32'(er));
      end
    end
  endtask

  task automatic rst;
    @(posedge i_mclk);
    i_rstn <= 1'b0;
    cmd <= '0;
    cyc(4);
    i_rstn <= 1'b1;
    cyc(4);
  endtask

  // p selects one of the five pumps; 5 leaves all pumps stopped
  task automatic perm(input int p);
    @(posedge i_mclk);
    cmd.prm_low <= 1'b1;
    cmd.lvl15_low <= 1'b1;
    {cmd.hpf_run, cmd.lpf_run} <= 5'h01 << p;
  endtask

  task automatic trip(input logic [3:0] d, input logic [3:0] l);
    @(posedge i_mclk);
    cmd.dw_trip <= d;
    cmd.lvl_trip <= l;
  endtask

  task automatic wait_init(input int lo, input int lim);
    int c;
    c = 0;
    while (a_in !== 1'b1 && c < lim) begin
      @(posedge i_mclk);
      c++;
    end
    check(32'(c >= lo && c < lim), 32'h1);
  endtask

  initial begin
    rst;
    rchk(ddil_pkg::REG_STATUS, 32'h0, ddil_pkg::RESP_OKAY);
    rchk(ddil_pkg::REG_CTRL, 32'h0, ddil_pkg::RESP_OKAY);
    wchk(ddil_pkg::REG_CTRL, 32'hFFFFFFFF, 4'hF, ddil_pkg::RESP_OKAY);
    rchk(ddil_pkg::REG_CTRL, 32'hF1, ddil_pkg::RESP_OKAY);
    wchk(ddil_pkg::REG_CTRL, 32'h0, 4'h0, ddil_pkg::RESP_OKAY);
    rchk(ddil_pkg::REG_CTRL, 32'hF1, ddil_pkg::RESP_OKAY);
    wchk(ddil_pkg::REG_STATUS, 32'hFF, 4'hF, ddil_pkg::RESP_OKAY);
    // test enable with all channels injected shows only as the shadow vote
    rchk(ddil_pkg::REG_STATUS, 32'h200, ddil_pkg::RESP_OKAY);
    wchk(8'h40, 32'h1, 4'hF, ddil_pkg::RESP_SLVERR);
    rchk(8'h40, 32'h0, ddil_pkg::RESP_SLVERR);
    $display("test registers done");
    for (int p = 0; p < 5; p++) begin
      rst;
      // test injection stays on during a genuine demand
      if (p == 0) wchk(ddil_pkg::REG_CTRL, 32'hF1, 4'hF, 2'h0);
      perm(p);
      trip(4'h1, 4'h1);
      cyc(6);
      check(32'({a_dw, a_lv}), 32'h0);
      trip(4'h5, 4'hA);
      wait_init(ADC - 4, ADC + 20);
      cyc(6);
      check(32'({a_dw, a_lv, pilot}), 32'h3FF);
      check(32'(pos[7:0]), 32'hFF);
      @(posedge i_mclk);
      cmd.reset_req <= 1'b1;
      cmd.div_inhibit <= 1'b1;
      cyc(8);
      check(32'({a_in, a_ih, pilot}), 32'h3FF);
      @(posedge i_mclk);
      cmd.reset_req <= 1'b0;
      trip(4'h0, 4'h0);
      cyc(8);
      check(32'({a_dw, a_lv, a_in, pilot}), 32'h7FF);
      @(posedge i_mclk);
      cmd.reset_req <= 1'b1;
      cyc(8);
      check(32'({a_dw, a_lv, a_in, pilot}), 32'h0);
    end
    $display("test auto done");
    for (int b = 0; b < 5; b++) begin
      rst;
      perm(b == 4 ? 5 : 0);
      @(posedge i_mclk);
      case (b)
        0: cmd.div_inhibit <= 1'b1;
        1: cmd.tws_inhibit <= 1'b1;
        2: cmd.prm_low <= 1'b0;
        3: cmd.lvl15_low <= 1'b0;
        default: cmd.reset_req <= 1'b0;
      endcase
      trip(4'h3, 4'h3);
      cyc(BYC + ADC + 40);
      check(32'({a_in, a_ih}), 32'(b == 0));
    end
    $display("test blocking done");
    rst;
    perm(1);
    trip(4'h3, 4'h3);
    cyc(10);
    check(32'(a_tm), 32'h1);
    trip(4'h3, 4'h8);
    cyc(8);
    check(32'({a_tm, a_in}), 32'h0);
    trip(4'h3, 4'hC);
    wait_init(ADC - 4, ADC + 20);
    rst;
    perm(2);
    trip(4'h0, 4'h9);
    cyc(10);
    check(32'({a_tm, a_dw}), 32'h2);
    wait_init(BYC + ADC - 16, BYC + ADC + 30);
    $display("test timing done");
    rst;
    @(posedge i_mclk);
    cmd.arm_collar <= 2'b01;
    cmd.pushbutton <= 2'b11;
    cyc(6);
    check(32'({a_ar, a_in}), 32'h0);
    @(posedge i_mclk);
    cmd.arm_collar <= 2'b11;
    cyc(6);
    check(32'({a_ar, a_in}), 32'h2);
    @(posedge i_mclk);
    cmd.hpf_run <= 2'b10;
    wait_init(0, 6);
    $display("test manual done");
    rst;
    @(posedge i_mclk);
    cmd.press_trip <= 4'h8;
    cmd.sel_auto <= 18'h3FFFF;
    cyc(6);
    check(32'(relief), 32'h0);
    @(posedge i_mclk);
    cmd.press_trip <= 4'h9;
    cyc(6);
    check(32'({grp, relief}), 32'h1FFFFF);
    @(posedge i_mclk);
    cmd.press_trip <= 4'h0;
    for (int g = 0; g < 3; g++) begin
      @(posedge i_mclk);
      cmd.sel_open <= 18'h00001 << (g * 6 + 5);
      cyc(12);
      check(32'({grp, relief}), 32'({3'h1 << g, 18'h1 << (g * 6 + 5)}));
      check(32'(pos), 32'(18'h1 << (g * 6 + 5)));
    end
    rchk(ddil_pkg::REG_POS, 32'h20000, ddil_pkg::RESP_OKAY);
    @(posedge i_mclk);
    cmd.temp_hi <= 18'h20000;
    cyc(6);
    check(32'(a_lk), 32'h1);
    @(posedge i_mclk);
    cmd.temp_hi <= 18'h00000;
    cyc(6);
    check(32'(a_lk), 32'h0);
    $display("test relief done");
    wrap_up;
  end

  initial begin
    #200000;
    mismatches++;
    wrap_up;
  end
endmodule

`default_nettype wire
